// ==== ccpd_pkg.sv ====
// Purpose: Shared constants for the clock power-down control block
// Assumes: One 200 MHz clock; all inputs synchronous to it
// Notes: Times kept in their own units, cycle counts derived from them
package ccpd_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned RESTART_MAX_US_X10 = 18000; // 1.8 ms, in tenths of a microsecond
  localparam int unsigned CPU_DRIVE_MAX_US = 300;
  // Longest times round down; restart must stay strictly below its limit
  localparam int unsigned RESTART_CYC = (RESTART_MAX_US_X10 * 100) / CLK_PERIOD_PS - 1;
  localparam int unsigned CPU_DRIVE_CYC = (CPU_DRIVE_MAX_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int unsigned CNT_W = 19;

  // ----------------------------------------
  // Power-down sampling
  // ----------------------------------------
  localparam logic [1:0] PD_LOWS_NEEDED = 2'h2;
  localparam logic [1:0] PD_LOWS_CLEAR = 2'h0;
  localparam logic [1:0] PD_LOWS_STEP = 2'h1;

  // ----------------------------------------
  // Output families
  // ----------------------------------------
  localparam int unsigned N_REF = 2;
  localparam int unsigned N_PCI = 9;
  localparam int unsigned N_V66 = 4;
  localparam int unsigned N_USB = 2;
  localparam int unsigned N_CPU = 3;

  // ----------------------------------------
  // Control states
  // ----------------------------------------
  typedef enum logic [2:0] {
    CCPD_RUN,
    CCPD_STOP,
    CCPD_DOWN,
    CCPD_WAKE
  } ccpd_state_t;

endpackage

// ==== ccpd_gate.sv ====
// Purpose: Glitch-free stop/start gate for one running clock source
// Assumes: src is a level synchronous to clk
// Notes: Stops only on a falling edge, restarts only while source is low
module ccpd_gate (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Source and control
  input wire logic src,
  input wire logic stop_req,
  // Gated result
  output logic gated_q,
  output logic stopped_q
);

  logic src_prev_q;
  logic en_q;
  logic en_d;

  always_comb begin
    en_d = en_q;
    if (en_q && stop_req && src_prev_q && !src) begin
      en_d = 1'b0;
    end else if (!en_q && !stop_req && !src) begin
      en_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      src_prev_q <= 1'b0;
      en_q <= 1'b1;
      gated_q <= 1'b0;
      stopped_q <= 1'b0;
    end else begin
      src_prev_q <= src;
      en_q <= en_d;
      gated_q <= en_d & src;
      stopped_q <= ~en_d;
    end
  end

endmodule

// ==== ccpd_top.sv ====
// Purpose: Power-down control for a multi-output clock synthesizer
// Assumes: PLL outputs arrive as levels synchronous to clk
// Notes: Restart counts are parameters so simulation can shorten them
module ccpd_top #(
  parameter int unsigned RESTART_CYC = ccpd_pkg::RESTART_CYC,
  parameter int unsigned CPU_DRIVE_CYC = ccpd_pkg::CPU_DRIVE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Power management
  input wire logic power_down_n,
  input wire logic cpu_tristate_pd,
  // PLL sources
  input wire logic pll_cpu,
  input wire logic pll_ref,
  input wire logic pll_pci,
  input wire logic pll_v66,
  input wire logic pll_usb,
  output logic pll_enable,
  // Single-ended outputs
  output logic [ccpd_pkg::N_REF-1:0] ref_out,
  output logic [ccpd_pkg::N_PCI-1:0] pci_out,
  output logic [ccpd_pkg::N_V66-1:0] v66_out,
  output logic [ccpd_pkg::N_USB-1:0] usb_out,
  // CPU differential outputs
  output logic [ccpd_pkg::N_CPU-1:0] cpu_clock_true_out,
  output logic [ccpd_pkg::N_CPU-1:0] cpu_clock_true_oe,
  output logic [ccpd_pkg::N_CPU-1:0] cpu_clock_comp_out,
  output logic [ccpd_pkg::N_CPU-1:0] cpu_clock_comp_oe,
  output logic cpu_bias_double,
  // Status
  output logic power_down_active
);

  ccpd_pkg::ccpd_state_t state_q;
  logic [1:0] pd_lows_q;
  logic comp_prev_q;
  logic [ccpd_pkg::CNT_W-1:0] wake_cnt_q;
  logic stop_req;
  logic cpu_g, cpu_clock_comp_out_g, ref_g, pci_g, v66_g, usb_g;
  logic cpu_s, cpu_clock_comp_out_s, ref_s, pci_s, v66_s, usb_s;
  logic all_stopped;
  logic comp_rise;
  logic pd_seen;

  // ----------------------------------------
  // Output gates
  // ----------------------------------------
  assign stop_req = (state_q != ccpd_pkg::CCPD_RUN);

  ccpd_gate u_cpu (.clk(clk), .resetn(resetn), .src(pll_cpu), .stop_req(stop_req),
    .gated_q(cpu_g), .stopped_q(cpu_s));
  ccpd_gate u_cpu_clock_comp_out (.clk(clk), .resetn(resetn), .src(~pll_cpu), .stop_req(stop_req),
    .gated_q(cpu_clock_comp_out_g), .stopped_q(cpu_clock_comp_out_s));
  ccpd_gate u_ref (.clk(clk), .resetn(resetn), .src(pll_ref), .stop_req(stop_req),
    .gated_q(ref_g), .stopped_q(ref_s));
  ccpd_gate u_pci (.clk(clk), .resetn(resetn), .src(pll_pci), .stop_req(stop_req),
    .gated_q(pci_g), .stopped_q(pci_s));
  ccpd_gate u_v66 (.clk(clk), .resetn(resetn), .src(pll_v66), .stop_req(stop_req),
    .gated_q(v66_g), .stopped_q(v66_s));
  ccpd_gate u_usb (.clk(clk), .resetn(resetn), .src(pll_usb), .stop_req(stop_req),
    .gated_q(usb_g), .stopped_q(usb_s));

  // A slow reference may take many fast cycles to fall; state waits for it
  assign all_stopped = cpu_s & cpu_clock_comp_out_s & ref_s & pci_s & v66_s & usb_s;

  assign ref_out = {ccpd_pkg::N_REF{ref_g}};
  assign pci_out = {ccpd_pkg::N_PCI{pci_g}};
  assign v66_out = {ccpd_pkg::N_V66{v66_g}};
  assign usb_out = {ccpd_pkg::N_USB{usb_g}};

  // ----------------------------------------
  // Power-down sampling on complement CPU edges
  // ----------------------------------------
  assign comp_rise = cpu_clock_comp_out_g & ~comp_prev_q;
  assign pd_seen = (pd_lows_q == ccpd_pkg::PD_LOWS_NEEDED);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      comp_prev_q <= 1'b0;
    end else begin
      comp_prev_q <= cpu_clock_comp_out_g;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pd_lows_q <= ccpd_pkg::PD_LOWS_CLEAR;
    end else if (state_q == ccpd_pkg::CCPD_WAKE) begin
      pd_lows_q <= ccpd_pkg::PD_LOWS_CLEAR;
    end else if (comp_rise) begin
      if (power_down_n) begin
        pd_lows_q <= ccpd_pkg::PD_LOWS_CLEAR;
      end else if (!pd_seen) begin
        pd_lows_q <= pd_lows_q + ccpd_pkg::PD_LOWS_STEP;
      end
    end
  end

  // ----------------------------------------
  // Control state
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ccpd_pkg::CCPD_RUN;
    end else begin
      case (state_q)
        ccpd_pkg::CCPD_RUN: begin
          if (pd_seen) begin
            state_q <= ccpd_pkg::CCPD_STOP;
          end
        end
        ccpd_pkg::CCPD_STOP: begin
          if (all_stopped) begin
            state_q <= ccpd_pkg::CCPD_DOWN;
          end
        end
        ccpd_pkg::CCPD_DOWN: begin
          if (power_down_n) begin
            state_q <= ccpd_pkg::CCPD_WAKE;
          end
        end
        ccpd_pkg::CCPD_WAKE: begin
          if (wake_cnt_q == RESTART_CYC[ccpd_pkg::CNT_W-1:0]) begin
            state_q <= ccpd_pkg::CCPD_RUN;
          end
        end
        default: begin
          state_q <= ccpd_pkg::CCPD_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_cnt_q <= '0;
    end else if (state_q == ccpd_pkg::CCPD_WAKE) begin
      wake_cnt_q <= wake_cnt_q + 1'b1;
    end else begin
      wake_cnt_q <= '0;
    end
  end

  // PLLs stay off only while fully down
  assign pll_enable = (state_q != ccpd_pkg::CCPD_DOWN);
  assign power_down_active = (state_q == ccpd_pkg::CCPD_DOWN);

  // ----------------------------------------
  // CPU pair drive
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_clock_true_out <= '0;
      cpu_clock_true_oe <= '1;
      cpu_clock_comp_out <= '0;
      cpu_clock_comp_oe <= '1;
      cpu_bias_double <= 1'b0;
    end else if (state_q == ccpd_pkg::CCPD_WAKE) begin
      // Static high/low drive gives swing well before clocks restart
      cpu_clock_true_out <= '1;
      cpu_clock_true_oe <= '1;
      cpu_clock_comp_out <= '0;
      cpu_clock_comp_oe <= '1;
      cpu_bias_double <= 1'b0;
    end else if (state_q == ccpd_pkg::CCPD_DOWN || (state_q == ccpd_pkg::CCPD_STOP && cpu_s && cpu_clock_comp_out_s)) begin
      cpu_clock_true_out <= {ccpd_pkg::N_CPU{~cpu_tristate_pd}};
      cpu_clock_true_oe <= {ccpd_pkg::N_CPU{~cpu_tristate_pd}};
      cpu_clock_comp_out <= '0;
      cpu_clock_comp_oe <= '0;
      cpu_bias_double <= ~cpu_tristate_pd;
    end else begin
      cpu_clock_true_out <= {ccpd_pkg::N_CPU{cpu_g}};
      cpu_clock_true_oe <= '1;
      cpu_clock_comp_out <= {ccpd_pkg::N_CPU{cpu_clock_comp_out_g}};
      cpu_clock_comp_oe <= '1;
      cpu_bias_double <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_STOP_ON_FALL: assert property (@(posedge clk) disable iff (!resetn)
    $fell(pci_g) |-> $past(pll_pci, 2) && !$past(pll_pci))
    else $error("pci output fell other than with its source");
  AST_TWO_LOWS: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == ccpd_pkg::CCPD_RUN) ##1 (state_q == ccpd_pkg::CCPD_STOP) |-> $past(pd_lows_q) == ccpd_pkg::PD_LOWS_NEEDED)
    else $error("power-down entered without two low samples");
  AST_DOWN_LOW: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == ccpd_pkg::CCPD_DOWN) |-> !ref_g && !pci_g && !v66_g && !usb_g && !cpu_clock_comp_out_g)
    else $error("output not low while powered down");
  AST_PARK_DEFAULT: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == ccpd_pkg::CCPD_DOWN) && !cpu_tristate_pd ##1 (state_q == ccpd_pkg::CCPD_DOWN)
    |-> cpu_clock_true_out[0] && cpu_clock_true_oe[0] && cpu_bias_double && !cpu_clock_comp_oe[0])
    else $error("cpu pair not in default park");
  AST_PARK_TRISTATE: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == ccpd_pkg::CCPD_DOWN) && cpu_tristate_pd ##1 (state_q == ccpd_pkg::CCPD_DOWN)
    |-> !cpu_clock_true_oe[0] && !cpu_clock_comp_oe[0])
    else $error("cpu pair driven while tri-state parking selected");
  AST_REF_WAIT: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == ccpd_pkg::CCPD_STOP) && !ref_s |=> state_q != ccpd_pkg::CCPD_DOWN)
    else $error("power-down reached before reference stopped");
  AST_RESTART_BOUND: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == ccpd_pkg::CCPD_WAKE) |-> wake_cnt_q <= RESTART_CYC[ccpd_pkg::CNT_W-1:0])
    else $error("restart exceeded its limit");
  AST_CPU_DRIVE: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == ccpd_pkg::CCPD_WAKE) && (wake_cnt_q != '0) && (wake_cnt_q < CPU_DRIVE_CYC[ccpd_pkg::CNT_W-1:0])
    |-> cpu_clock_true_oe[0] && cpu_clock_comp_oe[0] && cpu_clock_true_out[0])
    else $error("cpu pair not driven early in wake");
  AST_CLEAN_START: assert property (@(posedge clk) disable iff (!resetn)
    $rose(v66_g) |-> $past(pll_v66) && !$past(pll_v66, 2)
      && ($past(state_q) == ccpd_pkg::CCPD_RUN || $past(state_q) == ccpd_pkg::CCPD_STOP))
    else $error("v66 output restarted mid-pulse");

endmodule

// ==== ccpd_pm_model.sv ====
// Purpose: Power management partner that drives the power-down request
// Assumes: One clock; the request is driven away from the sampling edge
// Notes: The request level is taken from the bench and driven on the falling edge
module ccpd_pm_model (
  // Clock
  input wire logic clk,
  // Request from the bench, high asks for power-down
  input wire logic req,
  // Power-down line, active low
  output logic power_down_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Request drive
  // ----------------------------------------
  initial power_down_n = 1'b1;
  // Falling-edge drive keeps the level clear of the design's sampling edge
  always @(negedge clk) begin
    power_down_n <= ~req;
  end
endmodule

// ==== clock_power_down_control_test.sv ====
// Purpose: Self-checking bench for the clock power-down control block
// Assumes: Free-running sources made from one counter, changed on the falling edge
// Notes: Restart count shortened to keep the run short
module clock_power_down_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int unsigned RST = 50;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic pd_req = 1'b0;
  logic tri_pd = 1'b0;
  logic [3:0] src_cnt = 4'h0;
  logic power_down_n;
  logic pll_enable;
  logic [1:0] ref_out;
  logic [8:0] pci_out;
  logic [3:0] v66_out;
  logic [1:0] usb_out;
  logic [2:0] true_out, true_oe, comp_out, comp_oe;
  logic bias, power_down_active;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int ref_hi = 0;
  int usb_hi = 0;
  always #2.5 clk = ~clk;
  always @(negedge clk) src_cnt <= src_cnt + 4'h1;
  // ----------------------------------------
  // Design and partner
  // ----------------------------------------
  ccpd_pm_model pm (.clk(clk), .req(pd_req), .power_down_n(power_down_n));
  ccpd_top #(.RESTART_CYC(RST), .CPU_DRIVE_CYC(60)) uut (
    .clk(clk), .resetn(resetn), .power_down_n(power_down_n), .cpu_tristate_pd(tri_pd),
    .pll_cpu(src_cnt[1]), .pll_ref(src_cnt[2]), .pll_pci(src_cnt[2]), .pll_v66(src_cnt[1]),
    .pll_usb(src_cnt[3]), .pll_enable(pll_enable), .ref_out(ref_out), .pci_out(pci_out),
    .v66_out(v66_out), .usb_out(usb_out), .cpu_clock_true_out(true_out), .cpu_clock_true_oe(true_oe),
    .cpu_clock_comp_out(comp_out), .cpu_clock_comp_oe(comp_oe), .cpu_bias_double(bias),
    .power_down_active(power_down_active));
  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Every ref and usb high pulse must have the source's full width, so a runt on stop or restart shows
  // Sampled on the falling edge, where the registered outputs have settled
  always @(negedge clk) begin
    if (resetn) begin
      if (ref_out[0] === 1'b1) ref_hi++;
      else begin
        if (ref_hi != 0) check(ref_hi, 32'h4);
        ref_hi = 0;
      end
      if (usb_out[0] === 1'b1) usb_hi++;
      else begin
        if (usb_hi != 0) check(usb_hi, 32'h8);
        usb_hi = 0;
      end
    end
  end
  // Ceiling well above the four scenarios
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_run;
    check(pll_enable, 32'h1);
    check(power_down_active, 32'h0);
    $display("test run done");
  endtask
  // A low too short for two complement samples must be ignored
  task automatic t_glitch;
    logic seen;
    seen = 1'b0;
    @(negedge clk);
    pd_req = 1'b1;
    repeat (3) @(negedge clk);
    pd_req = 1'b0;
    repeat (30) begin
      @(posedge clk);
      #1;
      if (power_down_active !== 1'b0) seen = 1'b1;
    end
    check(seen, 32'h0);
    $display("test glitch done");
  endtask
  task automatic t_down(input logic tri_sel);
    int i;
    @(negedge clk);
    tri_pd = tri_sel;
    pd_req = 1'b1;
    for (i = 0; i < 200 && power_down_active !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check(power_down_active, 32'h1);
    check({ref_out, pci_out, v66_out, usb_out}, 32'h0);
    check(pll_enable, 32'h0);
    if (tri_sel) check({true_oe, comp_oe, bias}, 32'h0);
    else check({true_out, true_oe, comp_oe, bias}, {22'h0, 3'h7, 3'h7, 3'h0, 1'b1});
    @(negedge clk);
    pd_req = 1'b0;
    for (i = 0; i < 10 && comp_oe !== 3'h7; i++) begin
      @(posedge clk);
      #1;
    end
    check({true_out, true_oe, comp_out, comp_oe}, 32'hFC7);
    for (i = 0; i < RST + 40 && pci_out[0] !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check(pci_out[0], 32'h1);
    check(pll_enable, 32'h1);
    @(negedge clk);
    tri_pd = 1'b0;
    $display("test down done");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    // Release while all sources are low so no partial first pulse is seen
    @(negedge clk iff src_cnt == 4'hF);
    resetn = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    t_run();
    t_glitch();
    t_down(1'b0);
    t_down(1'b1);
    final_report();
  end
endmodule
